// ===== rtl/dual_pwm_pkg.sv
package dual_pwm_pkg;

  // Sizes
  localparam int UNITS = 2;
  localparam int CNT_W = 16;
  localparam int PRESC_W = 7;
  localparam int NCMP = 5;
  localparam int EV_W = 4;
  localparam int STAT_W = 8;

  // Unit register offsets inside one unit window (address bits 4:0)
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_CCR = 5'h04;
  localparam logic [4:0] REG_CRA = 5'h08;
  localparam logic [4:0] REG_CRB = 5'h0C;
  localparam logic [4:0] REG_DUTYA = 5'h10;
  localparam logic [4:0] REG_DUTYB = 5'h14;
  localparam logic [4:0] REG_COUNT = 5'h18;

  // Global register byte addresses
  localparam logic [6:0] REG_SYNC = 7'h40;
  localparam logic [6:0] REG_STATUS = 7'h44;
  localparam logic [6:0] REG_MASK = 7'h48;

  // Compare slots: capture_compare_reg, cycle_compare_reg_a/b, two duty values
  localparam int CMP_CCR = 0;
  localparam int CMP_CRA = 1;
  localparam int CMP_CRB = 2;
  localparam int CMP_DUTYA = 3;
  localparam int CMP_DUTYB = 4;

  // Event bit positions inside each unit's four status bits
  localparam int EV_PERIOD = 0;
  localparam int EV_ADC = 1;
  localparam int EV_CAPTURE = 2;
  localparam int EV_HIZ = 3;

  // Values after reset
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [STAT_W-1:0] STAT_RST = 8'h00;
  localparam logic [PRESC_W-1:0] PRESC_RST = 7'h00;

  typedef enum logic [1:0] {
    LOCK_NONE = 2'b00,
    LOCK_HOLD = 2'b01,
    LOCK_RESTART = 2'b10,
    LOCK_OUTRESET = 2'b11
  } lock_mode_e;

  typedef enum logic [1:0] {
    SYNC_OFF = 2'b00,
    SYNC_START = 2'b01,
    SYNC_START_CLEAR = 2'b10,
    SYNC_SPARE = 2'b11
  } sync_mode_e;

  // Per-unit control word, bit 0 is count_run_control
  typedef struct packed {
    logic [2:0] clkDiv;
    logic compl;
    logic idleB;
    logic idleA;
    logic [3:0] trigSel;
    logic gateEn;
    logic hizEn;
    lock_mode_e lockMode;
    logic capMode;
    logic reloadSel;
    logic run;
  } ctrl_s;

  localparam ctrl_s CTRL_RST = '0;

endpackage : dual_pwm_pkg

// ===== rtl/dual_pwm_timer_pair.sv
`timescale 1ns/10ps
// What this block does
// - Two units, 16-bit counter, two outputs each
// - Complementary pairs for half or full bridge
// - Period and duty change while counting
// - Idle output level set by software
// - Compare match pulses the converter start
// - Capture mode latches count on event
// - Sync start: both units start together
// - Sync start/clear: both clear together too
// - Gating timer output permits the outputs
// - Mode 1: input high holds reset, clear
// - Mode 2: rising edge restarts the count
// - Mode 3: edge resets outputs until period
// - Hi-Z control floats outputs on edge
// - Count clock: clock divided by 1, 2, 4 and so on up to 128
// - Run bit low stops and clears counter
// - Compare writes buffered until period match or restart edge, taken at once while stopped
// - Reset clears all compare registers
module dual_pwm_timer_pair
  import dual_pwm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Asynchronous event and gating inputs
  input wire logic [2:0] comparator_out,
  input wire logic external_irq_input,
  input wire logic gating_timer_output,
  // PWM pins
  output logic pwm_out_unit0_a,
  output logic pwm_out_unit0_a_oe,
  output logic pwm_out_unit0_b,
  output logic pwm_out_unit0_b_oe,
  output logic pwm_out_unit1_a,
  output logic pwm_out_unit1_a_oe,
  output logic pwm_out_unit1_b,
  output logic pwm_out_unit1_b_oe,
  // Converter start pulses and interrupt
  output logic adc_start_unit0,
  output logic adc_start_unit1,
  output logic irq
);

  // Merge write data under byte enables
  function automatic logic [31:0] beMerge(input logic [31:0] oldV, input logic [31:0] newV,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = oldV;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = newV[8*b +: 8];
      end
    end
    return r;
  endfunction : beMerge

  // Bus handshake state
  logic waitReqQ; // High except in the single answer cycle
  logic [31:0] readdataQ; // Read data, stable in the answer cycle
  logic [31:0] rdMux; // Combinational read select
  logic wrStrobe; // Write takes effect this edge

  // Software state
  ctrl_s ctrlQ [UNITS]; // Per-unit control words
  sync_mode_e syncQ; // Unit pairing mode
  logic [STAT_W-1:0] statusQ; // Sticky events
  logic [STAT_W-1:0] maskQ; // Interrupt enables
  logic [STAT_W-1:0] evtVec; // Event pulses from both units

  // Counter state
  logic [CNT_W-1:0] countQ [UNITS];
  logic [CNT_W-1:0] cmpQ [UNITS][NCMP]; // Active compare values
  logic [CNT_W-1:0] cmpBufQ [UNITS][NCMP]; // Buffered software writes
  logic outResetQ [UNITS]; // Mode 3 output reset latch
  logic [PRESC_W-1:0] prescQ; // Shared free-running prescaler

  // Per-unit combinational terms
  logic runEff [UNITS];
  logic tickEff [UNITS];
  logic periodHit [UNITS];
  logic trigLevel [UNITS];
  logic trigRise [UNITS];

  // Input synchronisers: {ext irq, comparators}, gate separate
  logic [3:0] evMetaQ;
  logic [3:0] evSyncQ;
  logic [3:0] evPrevQ;
  logic gateMetaQ;
  logic gateSyncQ;

  // Output flops
  logic [3:0] pwmOutQ;
  logic [3:0] pwmOeQ;
  logic [1:0] adcQ;
  logic irqQ;

  assign wrStrobe = avs_write && !waitReqQ;

  // One wait cycle, then a one-cycle answer; read data latched with it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitReqQ <= 1'b1;
      readdataQ <= 32'h00000000;
    end else if ((avs_read || avs_write) && waitReqQ) begin
      waitReqQ <= 1'b0;
      readdataQ <= avs_read ? rdMux : 32'h00000000;
    end else begin
      waitReqQ <= 1'b1;
    end
  end

  // Read select; unmapped addresses read zero
  always_comb begin
    rdMux = 32'h00000000;
    if (!avs_address[6]) begin
      if (avs_address[4:0] == REG_CTRL) begin
        rdMux = 32'(ctrlQ[avs_address[5]]);
      end else if (avs_address[4:0] == REG_COUNT) begin
        rdMux = {16'h0000, countQ[avs_address[5]]};
      end else if (avs_address[4:0] == REG_CCR) begin
        // Shows captured value in capture mode
        rdMux = {16'h0000, cmpQ[avs_address[5]][CMP_CCR]};
      end else if (avs_address[4:0] >= REG_CRA && avs_address[4:0] <= REG_DUTYB
                   && avs_address[1:0] == 2'b00) begin
        rdMux = {16'h0000, cmpBufQ[avs_address[5]][3'(avs_address[4:2] - 3'h1)]};
      end
    end else if (avs_address == REG_SYNC) begin
      rdMux = {30'h00000000, syncQ};
    end else if (avs_address == REG_STATUS) begin
      rdMux = {24'h000000, statusQ};
    end else if (avs_address == REG_MASK) begin
      rdMux = {24'h000000, maskQ};
    end
  end

  // Global registers; a new event beats a same-cycle clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncQ <= SYNC_OFF;
      statusQ <= STAT_RST;
      maskQ <= STAT_RST;
    end else begin
      if (wrStrobe && avs_address == REG_SYNC && avs_byteenable[0]) begin
        syncQ <= sync_mode_e'(avs_writedata[1:0]);
      end
      if (wrStrobe && avs_address == REG_MASK && avs_byteenable[0]) begin
        maskQ <= avs_writedata[STAT_W-1:0];
      end
      if (wrStrobe && avs_address == REG_STATUS && avs_byteenable[0]) begin
        statusQ <= (statusQ & ~avs_writedata[STAT_W-1:0]) | evtVec;
      end else begin
        statusQ <= statusQ | evtVec;
      end
    end
  end

  // Level interrupt, one cycle behind the status bits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqQ <= 1'b0;
    end else begin
      irqQ <= |(statusQ & maskQ);
    end
  end

  // Two-flop synchronisers, then an edge history stage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      evMetaQ <= 4'h0;
      evSyncQ <= 4'h0;
      evPrevQ <= 4'h0;
      gateMetaQ <= 1'b0;
      gateSyncQ <= 1'b0;
    end else begin
      evMetaQ <= {external_irq_input, comparator_out};
      evSyncQ <= evMetaQ;
      evPrevQ <= evSyncQ;
      gateMetaQ <= gating_timer_output;
      gateSyncQ <= gateMetaQ;
    end
  end

  // Prescaler shared so paired units tick on the same edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prescQ <= PRESC_RST;
    end else begin
      prescQ <= prescQ + 7'h01;
    end
  end

  for (genvar u = 0; u < UNITS; u++) begin : g_unit
    logic [2:0] divSel;
    logic [PRESC_W-1:0] divMask;
    logic holdNow;
    logic restartNow;
    logic outResetSet;
    logic loadNow;
    logic adcHit;
    logic capHit;
    logic rawA;
    logic rawB;
    logic quiet;
    logic unitWr;
    logic [2:0] slot;
    logic [CNT_W-1:0] periodVal;

    // sync modes borrow unit 0 run and divider
    assign runEff[u] = (syncQ == SYNC_START || syncQ == SYNC_START_CLEAR) ? ctrlQ[0].run
                                                                          : ctrlQ[u].run;
    assign divSel = (syncQ == SYNC_START || syncQ == SYNC_START_CLEAR) ? ctrlQ[0].clkDiv
                                                                      : ctrlQ[u].clkDiv;
    // clkDiv n ticks once every 2**n clocks, so 0 ticks on every clock
    assign divMask = ~(7'h7F << divSel);
    assign tickEff[u] = (prescQ & divMask) == divMask;

    assign trigLevel[u] = |(evSyncQ & ctrlQ[u].trigSel);
    assign trigRise[u] = trigLevel[u] && !(|(evPrevQ & ctrlQ[u].trigSel));

    assign periodVal = ctrlQ[u].reloadSel ? cmpQ[u][CMP_CRB] : cmpQ[u][CMP_CRA];
    assign periodHit[u] = runEff[u] && tickEff[u] && countQ[u] == periodVal;

    // exactly one interlock mode, none ignores events
    always_comb begin
      holdNow = 1'b0;
      restartNow = 1'b0;
      outResetSet = 1'b0;
      unique case (ctrlQ[u].lockMode)
        LOCK_NONE: begin
        end
        LOCK_HOLD: begin
          holdNow = trigLevel[u];
        end
        LOCK_RESTART: begin
          restartNow = trigRise[u];
        end
        LOCK_OUTRESET: begin
          outResetSet = trigRise[u];
        end
      endcase
    end

    // reload at period match, restart, or while stopped
    assign loadNow = !runEff[u] || periodHit[u] || restartNow;
    assign adcHit = runEff[u] && tickEff[u] && !ctrlQ[u].capMode
                    && countQ[u] == cmpQ[u][CMP_CCR];
    assign capHit = ctrlQ[u].capMode && trigRise[u];
    // floating latch set on valid edge
    assign evtVec[EV_W*u +: EV_W] = {ctrlQ[u].hizEn && trigRise[u], capHit, adcHit,
                                     periodHit[u]};

    assign unitWr = wrStrobe && !avs_address[6] && avs_address[5] == u[0];
    assign slot = 3'(avs_address[4:2] - 3'h1);

    // Control word
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        ctrlQ[u] <= CTRL_RST;
      end else if (unitWr && avs_address[4:0] == REG_CTRL) begin
        ctrlQ[u] <= ctrl_s'(beMerge(32'(ctrlQ[u]), avs_writedata, avs_byteenable));
      end
    end

    // compare buffers and active values clear at reset
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        for (int k = 0; k < NCMP; k++) begin
          cmpBufQ[u][k] <= CNT_RST;
          cmpQ[u][k] <= CNT_RST;
        end
      end else begin
        if (unitWr && avs_address[4:0] >= REG_CCR && avs_address[4:0] <= REG_DUTYB
            && avs_address[1:0] == 2'b00) begin
          cmpBufQ[u][slot] <= 16'(beMerge({16'h0000, cmpBufQ[u][slot]}, avs_writedata,
                                           avs_byteenable));
        end
        // running counter picks up new values here
        for (int k = 0; k < NCMP; k++) begin
          if (k == CMP_CCR && capHit) begin
            cmpQ[u][k] <= countQ[u];
          end else if (loadNow && !(k == CMP_CCR && ctrlQ[u].capMode)) begin
            cmpQ[u][k] <= cmpBufQ[u][k];
          end
        end
      end
    end

    // Counter with clear priorities
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        countQ[u] <= CNT_RST;
      end else if (!runEff[u]) begin
        countQ[u] <= CNT_RST;
      end else if (holdNow || restartNow) begin
        countQ[u] <= CNT_RST;
      end else if (u == 1 && syncQ == SYNC_START_CLEAR && periodHit[0]) begin
        // unit 1 clears with unit 0
        countQ[u] <= CNT_RST;
      end else if (tickEff[u]) begin
        countQ[u] <= periodHit[u] ? CNT_RST : countQ[u] + 16'h0001;
      end
    end

    // output reset until the next period interrupt
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        outResetQ[u] <= 1'b0;
      end else if (outResetSet) begin
        outResetQ[u] <= 1'b1;
      end else if (periodHit[u] || !runEff[u]) begin
        outResetQ[u] <= 1'b0;
      end
    end

    assign rawA = countQ[u] < cmpQ[u][CMP_DUTYA];
    assign rawB = ctrlQ[u].compl ? !rawA : countQ[u] < cmpQ[u][CMP_DUTYB];
    // gating timer low parks the outputs
    assign quiet = !runEff[u] || holdNow || outResetQ[u]
                   || (ctrlQ[u].gateEn && !gateSyncQ);

    // Pin flops; quiet forces idle levels, floating drops enables
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        pwmOutQ[2*u +: 2] <= 2'b00;
        pwmOeQ[2*u +: 2] <= 2'b00;
        adcQ[u] <= 1'b0;
      end else begin
        pwmOutQ[2*u +: 2] <= quiet ? {ctrlQ[u].idleB, ctrlQ[u].idleA} : {rawB, rawA};
        pwmOeQ[2*u +: 2] <= statusQ[EV_W*u + EV_HIZ] ? 2'b00 : 2'b11;
        adcQ[u] <= adcHit;
      end
    end
  end

  // Port drive straight from flops
  assign avs_waitrequest = waitReqQ;
  assign avs_readdata = readdataQ;
  assign pwm_out_unit0_a = pwmOutQ[0];
  assign pwm_out_unit0_b = pwmOutQ[1];
  assign pwm_out_unit1_a = pwmOutQ[2];
  assign pwm_out_unit1_b = pwmOutQ[3];
  assign pwm_out_unit0_a_oe = pwmOeQ[0];
  assign pwm_out_unit0_b_oe = pwmOeQ[1];
  assign pwm_out_unit1_a_oe = pwmOeQ[2];
  assign pwm_out_unit1_b_oe = pwmOeQ[3];
  assign adc_start_unit0 = adcQ[0];
  assign adc_start_unit1 = adcQ[1];
  assign irq = irqQ;

  // Checks on unit 0 behaviour, the unit 1 sync clear and the bus
  AST_STOP_CLEARS: assert property (@(posedge clk) disable iff (sys_rst)
    !runEff[0] |=> countQ[0] == CNT_RST && pwmOutQ[0] == $past(ctrlQ[0].idleA))
    else $error("stopped counter not cleared");
  AST_HOLD_MODE: assert property (@(posedge clk) disable iff (sys_rst)
    runEff[0] && ctrlQ[0].lockMode == LOCK_HOLD && trigLevel[0] |=> countQ[0] == CNT_RST)
    else $error("hold mode did not clear count");
  AST_RESTART_MODE: assert property (@(posedge clk) disable iff (sys_rst)
    runEff[0] && ctrlQ[0].lockMode == LOCK_RESTART && trigRise[0] |=> countQ[0] == CNT_RST)
    else $error("restart edge ignored");
  AST_CAPTURE: assert property (@(posedge clk) disable iff (sys_rst)
    ctrlQ[0].capMode && trigRise[0] |=> cmpQ[0][CMP_CCR] == $past(countQ[0]))
    else $error("capture value wrong");
  AST_ADC_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
    runEff[0] && tickEff[0] && !ctrlQ[0].capMode && countQ[0] == cmpQ[0][CMP_CCR]
    |=> adc_start_unit0 && statusQ[EV_ADC])
    else $error("compare match gave no pulse");
  AST_HIZ_FLOAT: assert property (@(posedge clk) disable iff (sys_rst)
    ctrlQ[0].hizEn && trigRise[0] |=> ##1 !pwm_out_unit0_a_oe && !pwm_out_unit0_b_oe)
    else $error("outputs not floated");
  AST_SYNC_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    syncQ == SYNC_START_CLEAR && periodHit[0] |=> countQ[1] == CNT_RST)
    else $error("unit 1 not cleared with unit 0");
  AST_BUFFER_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    runEff[0] && !periodHit[0] && ctrlQ[0].lockMode != LOCK_RESTART
    |=> $stable(cmpQ[0][CMP_DUTYA]))
    else $error("duty changed mid period");
  AST_OUTRESET: assert property (@(posedge clk) disable iff (sys_rst)
    runEff[0] && ctrlQ[0].lockMode == LOCK_OUTRESET && trigRise[0]
    |=> ##1 pwm_out_unit0_a == ctrlQ[0].idleA)
    else $error("output reset not applied");
  AST_BUS_ANSWER: assert property (@(posedge clk) disable iff (sys_rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");

endmodule : dual_pwm_timer_pair

// ===== test/bridge_model.sv
`timescale 1ns/10ps
// Power stage legs and the trip comparators that follow the bench trip requests
module bridge_model (
  // Clock
  input wire logic clk,
  // Gate drive from the timer pair
  input wire logic [3:0] gateDrive,
  input wire logic [3:0] gateOe,
  // Trip requests from the bench
  input wire logic [3:0] tripReq,
  // Comparator and external trip levels
  output logic [2:0] comparator_out,
  output logic external_irq_input,
  // Leg levels seen by the bridge
  output logic [3:0] legLevel
);
  // Quiet trip lines from time zero
  initial begin
    comparator_out = 3'h0;
    external_irq_input = 1'b0;
  end
  // Trip levels move just after an edge, as a slow comparator would
  always @(posedge clk) begin
    comparator_out <= tripReq[2:0];
    external_irq_input <= tripReq[3];
  end
  // Floating legs fall to the gate driver pull-down, never the last level
  always_comb begin
    legLevel = gateDrive & gateOe;
  end
endmodule : bridge_model

// ===== test/test_dual_pwm_timer_pair.sv
`timescale 1ns/10ps
module test_dual_pwm_timer_pair;
  import dual_pwm_pkg::*;
  // Clock, reset and bus drive
  logic clk, sys_rst;
  logic [6:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rq;
  logic [3:0] avs_byteenable, tripReq, legLevel;
  // Trip, gating and outputs
  logic [2:0] comparator_out;
  logic external_irq_input, gating_timer_output, irq;
  logic pwm_out_unit0_a, pwm_out_unit0_a_oe, pwm_out_unit0_b, pwm_out_unit0_b_oe;
  logic pwm_out_unit1_a, pwm_out_unit1_a_oe, pwm_out_unit1_b, pwm_out_unit1_b_oe;
  logic adc_start_unit0, adc_start_unit1;
  // Tallies
  int fails, samples_checked, hA, hB, ad, dif, a1, b1;
  // Register rows: address, write value, expected read
  typedef struct packed {
    logic [6:0] a;
    logic [31:0] w;
    logic [31:0] r;
  } row_s;
  row_s rows [10] = '{
    '{7'h08, 32'h0000_0009, 32'h0000_0009},
    '{7'h10, 32'h0000_0004, 32'h0000_0004},
    '{7'h14, 32'h1234_ABCD, 32'h0000_ABCD},
    '{7'h04, 32'h0000_0003, 32'h0000_0003},
    '{7'h18, 32'h0000_FFFF, 32'h0000_0000},
    '{7'h1C, 32'hFFFF_FFFF, 32'h0000_0000},
    '{7'h4C, 32'hFFFF_FFFF, 32'h0000_0000},
    '{7'h48, 32'h0000_0002, 32'h0000_0002},
    '{7'h28, 32'h0000_0009, 32'h0000_0009},
    '{7'h30, 32'h0000_0004, 32'h0000_0004}};

  dual_pwm_timer_pair u_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .comparator_out(comparator_out),
    .external_irq_input(external_irq_input), .gating_timer_output(gating_timer_output),
    .pwm_out_unit0_a(pwm_out_unit0_a), .pwm_out_unit0_a_oe(pwm_out_unit0_a_oe),
    .pwm_out_unit0_b(pwm_out_unit0_b), .pwm_out_unit0_b_oe(pwm_out_unit0_b_oe),
    .pwm_out_unit1_a(pwm_out_unit1_a), .pwm_out_unit1_a_oe(pwm_out_unit1_a_oe),
    .pwm_out_unit1_b(pwm_out_unit1_b), .pwm_out_unit1_b_oe(pwm_out_unit1_b_oe),
    .adc_start_unit0(adc_start_unit0), .adc_start_unit1(adc_start_unit1), .irq(irq));

  // Far side: bridge legs and comparators
  bridge_model u_bridge (.clk(clk),
    .gateDrive({pwm_out_unit1_b, pwm_out_unit1_a, pwm_out_unit0_b, pwm_out_unit0_a}),
    .gateOe({pwm_out_unit1_b_oe, pwm_out_unit1_a_oe, pwm_out_unit0_b_oe, pwm_out_unit0_a_oe}),
    .tripReq(tripReq), .comparator_out(comparator_out),
    .external_irq_input(external_irq_input), .legLevel(legLevel));

  // Free-running 125 MHz clock
  always #4 clk = ~clk;

  // Compare and tally
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One transfer, held until waitrequest is sampled low; bounded wait
  task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) fails++;
    rq = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus

  // Short bus wrappers
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [6:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Count high cycles, converter pulses and unit disagreement
  task automatic watch(input int n);
    hA = 0;
    hB = 0;
    ad = 0;
    dif = 0;
    a1 = 0;
    b1 = 0;
    repeat (n) begin
      @(posedge clk);
      hA += int'(pwm_out_unit0_a);
      hB += int'(pwm_out_unit0_b);
      ad += int'(adc_start_unit0);
      dif += int'(pwm_out_unit0_a !== pwm_out_unit1_a);
      a1 += int'(adc_start_unit1);
      b1 += int'(pwm_out_unit1_b);
    end
  endtask : watch

  // One trip pulse, long enough to pass the synchronisers
  task automatic trip(input logic [3:0] t);
    tripReq <= t;
    repeat (10) @(posedge clk);
    tripReq <= 4'h0;
    repeat (10) @(posedge clk);
  endtask : trip

  // Verdict and end of run
  task automatic close_out();
    if (fails == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // Watchdog sized well above the whole sequence
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end

  // Main sequence
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    avs_address = 7'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    gating_timer_output = 1'b1;
    tripReq = 4'h0;
    repeat (12) @(posedge clk);
    // Outputs parked while reset is held
    check("oe in reset", 32'(pwm_out_unit0_a_oe), 32'h0);
    check("wait in reset", 32'(avs_waitrequest), 32'h1);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int u = 0; u < 2; u++) begin
      for (int k = 1; k < 6; k++) begin
        rd(7'(u * 32 + k * 4));
        check("compare reset", rq, 32'h0000_0000);
      end
    end
    // Table rows: write then read back
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      check("register row", rq, rows[i].r);
    end
    wr(7'h00, 32'h0000_2001);
    repeat (25) @(posedge clk);
    watch(20);
    check("duty A", 32'(hA), 32'h8);
    check("duty B", 32'(hB), 32'hC);
    check("adc pulses", 32'(ad), 32'h2);
    check("irq on match", 32'(irq), 32'h1);
    wr(7'h08, 32'h0000_0004);
    wr(7'h10, 32'h0000_0002);
    repeat (25) @(posedge clk);
    watch(20);
    check("new duty", 32'(hA), 32'h8);
    check("new period", 32'(ad), 32'h4);
    gating_timer_output <= 1'b0;
    wr(7'h00, 32'h0000_3841);
    repeat (5) @(posedge clk);
    watch(10);
    check("idle A", 32'(hA), 32'hA);
    check("idle B", 32'(hB), 32'hA);
    gating_timer_output <= 1'b1;
    repeat (5) @(posedge clk);
    watch(20);
    check("gate open", 32'(hA), 32'h8);
    // Interrupt masked, then cleared
    wr(REG_MASK, 32'h0000_0000);
    repeat (3) @(posedge clk);
    check("irq masked", 32'(irq), 32'h0);
    wr(7'h00, 32'h0000_0000);
    wr(REG_STATUS, 32'h0000_00FF);
    rd(REG_STATUS);
    check("status cleared", rq, 32'h0000_0000);
    rd(7'h18);
    check("stopped count", rq, 32'h0000_0000);
    wr(7'h08, 32'h0000_03E8);
    wr(7'h00, 32'h0000_0C09);
    tripReq <= 4'h8;
    repeat (10) @(posedge clk);
    rd(7'h18);
    check("held count", rq, 32'h0000_0000);
    check("held output", 32'(pwm_out_unit0_a), 32'h1);
    tripReq <= 4'h0;
    repeat (10) @(posedge clk);
    rd(7'h18);
    check("resumed", 32'(rq > 32'h0 && rq < 32'h28), 32'h1);
    wr(7'h00, 32'h0000_0091);
    repeat (200) @(posedge clk);
    trip(4'h1);
    rd(7'h18);
    check("restarted", 32'(rq < 32'h32), 32'h1);
    wr(7'h00, 32'h0000_0000);
    wr(7'h00, 32'h0000_0081);
    repeat (150) @(posedge clk);
    trip(4'h1);
    rd(7'h18);
    check("trip ignored", 32'(rq > 32'h96), 32'h1);
    wr(7'h00, 32'h0000_0000);
    wr(7'h00, 32'h0000_0085);
    repeat (100) @(posedge clk);
    trip(4'h1);
    rd(7'h04);
    check("captured", 32'(rq > 32'h5F && rq < 32'h78), 32'h1);
    rd(REG_STATUS);
    check("capture flag", 32'(rq[2]), 32'h1);
    wr(7'h00, 32'h0000_0000);
    wr(7'h00, 32'h0000_0421);
    trip(4'h8);
    check("floated", 32'(pwm_out_unit0_a_oe), 32'h0);
    check("leg pulled low", 32'(legLevel[0]), 32'h0);
    wr(REG_STATUS, 32'h0000_0008);
    repeat (3) @(posedge clk);
    check("driven again", 32'(pwm_out_unit0_a_oe), 32'h1);
    wr(7'h00, 32'h0000_0000);
    wr(7'h08, 32'h0000_0009);
    wr(7'h10, 32'h0000_0004);
    wr(7'h34, 32'h0000_0004);
    wr(REG_SYNC, 32'h0000_0001);
    wr(7'h00, 32'h0000_0001);
    repeat (30) @(posedge clk);
    watch(20);
    check("sync start", 32'(dif), 32'h0);
    check("sync duty", 32'(hA), 32'h8);
    check("unit 1 B", 32'(b1), 32'h8);
    check("unit 1 pulses", 32'(a1), 32'h2);
    check("unit 1 driven", 32'({pwm_out_unit1_a_oe, pwm_out_unit1_b_oe}), 32'h3);
    // unit 1 cleared on unit 0 period
    wr(7'h00, 32'h0000_0000);
    wr(REG_SYNC, 32'h0000_0002);
    wr(7'h28, 32'h0000_0013);
    wr(7'h00, 32'h0000_0001);
    repeat (30) @(posedge clk);
    watch(20);
    check("sync clear", 32'(dif), 32'h0);
    check("unit 1 cleared pulses", 32'(a1), 32'h2);
    // outputs idle from trip edge to period end
    wr(7'h00, 32'h0000_0000);
    wr(7'h08, 32'h0000_03E8);
    wr(7'h10, 32'h0000_03E8);
    wr(7'h00, 32'h0000_0099);
    repeat (20) @(posedge clk);
    check("output running", 32'({pwm_out_unit0_b, pwm_out_unit0_a}), 32'h3);
    trip(4'h1);
    check("output reset", 32'({pwm_out_unit0_b, pwm_out_unit0_a}), 32'h0);
    repeat (1000) @(posedge clk);
    check("output released", 32'({pwm_out_unit0_b, pwm_out_unit0_a}), 32'h3);
    // divided count clock, second period register
    wr(7'h00, 32'h0000_0000);
    wr(7'h0C, 32'h0000_0004);
    wr(7'h10, 32'h0000_0002);
    wr(7'h00, 32'h0000_4003);
    repeat (25) @(posedge clk);
    watch(20);
    check("divided duty", 32'(hA), 32'h8);
    check("divided pulses", 32'(ad), 32'h2);
    // reset in mid-run clears compare state
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    check("outputs in reset", 32'({pwm_out_unit0_a_oe, adc_start_unit0, adc_start_unit1, irq}),
          32'h0);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(7'h28);
    check("compare after reset", rq, 32'h0000_0000);
    rd(7'h04);
    check("ccr after reset", rq, 32'h0000_0000);
    close_out();
  end
endmodule : test_dual_pwm_timer_pair
